// ---- hdl/aort_top.sv ----
// alarm output and relay trigger block with apb configuration
//
// Functional notes
// [R1] five digital outputs, each separately configured
// [R2] source: supply alarm, supply state, digital input
// [R3] alarm source: any unit shows selected alarm
// [R4] supply on: at least one unit running
// [R5] supply off: remote off/alarm, or all disconnected
// [R6] input source: selected input at high/low
// [R7] output level high or low while triggered
// [R8] outputs wait configured delay before asserting
// [R9] four relays, same options, no level setting
// [R10] relay common to open contact when triggered
// [R11] relays wait configured delay before switching
// [R12] unconnected digital input reads high
// [R13] delay restarts on clear; release immediate
// [R14] minute delays one to ten, second tick
//
// Added by the designer: the APB slave port and the register addresses.
`timescale 1ns/1ps
module aort_top #(
  parameter int unsigned TICK_CYCLES = aort_pkg::TICK_CYC
) (
  // clock and reset
  input  wire logic                        clock,
  input  wire logic                        rst_n,
  // apb slave
  input  wire logic                        psel,
  input  wire logic                        penable,
  input  wire logic                        pwrite,
  input  wire logic [7:0]                  paddr,
  input  wire logic [31:0]                 pwdata,
  output logic      [31:0]                 prdata,
  output logic                             pready,
  output logic                             pslverr,
  // supply unit status
  input  wire aort_pkg::aort_su_t          su_status,
  // field pins
  input  wire logic [aort_pkg::N_DI-1:0]   digital_input_channel,
  output logic      [aort_pkg::N_DO-1:0]   do_pin,
  output logic      [aort_pkg::N_RLY-1:0]  relay_no_closed
);
  import aort_pkg::*;

  logic [N_DI-1:0]   di_meta_q;
  logic [N_DI-1:0]   di_q;
  logic [24:0]       sub_cnt_q [N_CH];
  aort_cfg_t         cfg_q [N_CH];
  logic [9:0]        dly_cnt_q [N_CH];
  logic [N_CH-1:0]   trig;
  logic [N_CH-1:0]   asserted_q;
  logic [N_DO-1:0]   do_pin_q;
  logic [N_RLY-1:0]  relay_q;
  logic [31:0]       prdata_q;
  logic              pready_q;
  logic              pslverr_q;

  // input pins pass two flops; reset high like an open input
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      di_meta_q <= 5'h1f; // R12
      di_q      <= 5'h1f; // R12
    end else begin
      di_meta_q <= digital_input_channel;
      di_q      <= di_meta_q;
    end
  end

  // aggregated supply unit conditions
  wire [N_SU-1:0] unit_alarm = su_status.over_voltage_alarm | su_status.overload_alarm
                             | su_status.short_alarm | su_status.over_temp_alarm
                             | su_status.mains_loss_alarm | su_status.fan_stall_alarm;
  wire any_alarm   = |unit_alarm;
  wire any_ov      = |su_status.over_voltage_alarm;
  wire any_ol      = |su_status.overload_alarm;
  wire any_short   = |su_status.short_alarm;
  wire any_ot      = |su_status.over_temp_alarm;
  wire any_mains   = |su_status.mains_loss_alarm;
  wire any_fan     = |su_status.fan_stall_alarm;
  wire any_running = |su_status.running; // R4
  wire supply_off  = (|(su_status.remote_off | unit_alarm)) | ~(|su_status.connected); // R5

  // apb decode
  wire        acc      = psel & penable & ~pready_q;
  wire [5:0]  widx     = paddr[7:2];
  wire        hit_cfg  = (paddr >= OFS_CFG0) && (widx < 6'(N_CH)) && (paddr[1:0] == 2'h0);
  wire        hit_stat = (paddr == OFS_STATUS);
  wire        wr_cfg   = acc & pwrite & hit_cfg;
  wire [31:0] status_w = {9'h000, di_q, trig, asserted_q};

  // per-channel trigger selection and delay timer
  genvar g;
  generate
    for (g = 0; g < N_CH; g++) begin : g_ch
      aort_cfg_t  c;
      logic       alarm_hit;
      logic       di_lvl;
      logic [9:0] target;
      logic       sub_wrap;
      logic       sec_step;
      logic       done;
      assign c = cfg_q[g];
      // alarm kind selection
      assign alarm_hit = (c.cond == AL_ANY)   ? any_alarm :
                         (c.cond == AL_OV)    ? any_ov    :
                         (c.cond == AL_OL)    ? any_ol    :
                         (c.cond == AL_SHORT) ? any_short :
                         (c.cond == AL_OT)    ? any_ot    :
                         (c.cond == AL_MAINS) ? any_mains :
                         (c.cond == AL_FAN)   ? any_fan   : 1'b0; // R3
      assign di_lvl = (c.di_sel < 3'(N_DI)) ? di_q[c.di_sel] : 1'b0;
      // source selection; unknown combinations never trigger
      assign trig[g] =
        (c.src == SRC_ALARM)  ? alarm_hit : // R2
        (c.src == SRC_SUPPLY) ? ((c.cond == COND_ON_HIGH) ? any_running : // R4
                                 (c.cond == COND_OFF_LOW) ? supply_off : 1'b0) : // R5
        (c.src == SRC_DI)     ? ((c.di_sel < 3'(N_DI)) &&
                                 (((c.cond == COND_ON_HIGH) && di_lvl) ||
                                  ((c.cond == COND_OFF_LOW) && !di_lvl))) : 1'b0; // R6
      // delay target and one second step pulse
      assign target   = dly_secs(c.dly); // R8 R11 R14
      assign sub_wrap = (sub_cnt_q[g] == 25'(TICK_CYCLES - 1));
      assign sec_step = sub_wrap && (dly_cnt_q[g] < target);
      assign done     = (dly_cnt_q[g] >= target);
      // config register write
      always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
          cfg_q[g] <= CFG_RST;
        end else if (wr_cfg && (widx == 6'(g))) begin
          cfg_q[g] <= pwdata[CFG_W-1:0]; // R1
        end
      end
      // own second divider; phase starts with the trigger so no delay fires early
      always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
          sub_cnt_q[g] <= 25'h0000000;
        end else if (!trig[g] || done) begin
          sub_cnt_q[g] <= 25'h0000000; // R13
        end else if (sub_wrap) begin
          sub_cnt_q[g] <= 25'h0000000; // R14
        end else begin
          sub_cnt_q[g] <= sub_cnt_q[g] + 25'h0000001; // R14
        end
      end
      // seconds counter; cleared whenever the trigger drops
      always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
          dly_cnt_q[g]  <= 10'h000;
          asserted_q[g] <= 1'b0;
        end else if (!trig[g]) begin
          dly_cnt_q[g]  <= 10'h000; // R13
          asserted_q[g] <= 1'b0;    // R13
        end else begin
          if (sec_step) begin
            dly_cnt_q[g] <= dly_cnt_q[g] + 10'h001;
          end
          asserted_q[g] <= done; // R8 R11
        end
      end
      // field pin flop; relays have no level setting
      if (g < N_DO) begin : g_do
        always_ff @(posedge clock or negedge rst_n) begin
          if (!rst_n) begin
            do_pin_q[g] <= 1'b0;
          end else begin
            do_pin_q[g] <= asserted_q[g] ^ c.act_low; // R7
          end
        end
      end else begin : g_rly
        always_ff @(posedge clock or negedge rst_n) begin
          if (!rst_n) begin
            relay_q[g - N_DO] <= 1'b0;
          end else begin
            relay_q[g - N_DO] <= asserted_q[g]; // R9 R10
          end
        end
      end
    end
  endgenerate

  // apb read data and answer, one wait state per access
  wire [31:0] rd_w = hit_cfg  ? {19'h00000, cfg_q[widx[3:0]]} :
                     hit_stat ? status_w : 32'h00000000;
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      prdata_q  <= 32'h00000000;
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
    end else begin
      pready_q  <= acc;
      pslverr_q <= acc & ~(hit_cfg | (hit_stat & ~pwrite));
      if (acc && !pwrite) begin
        prdata_q <= rd_w;
      end
    end
  end

  assign prdata          = prdata_q;
  assign pready          = pready_q;
  assign pslverr         = pslverr_q;
  assign do_pin          = do_pin_q;
  assign relay_no_closed = relay_q;
endmodule

// ---- hdl/aort_pkg.sv ----
// shared constants and types for the alarm output and relay trigger block
package aort_pkg;
  localparam int unsigned N_DO    = 5;         // digital output channels
  localparam int unsigned N_RLY   = 4;         // relays
  localparam int unsigned N_CH    = 9;         // do channels first, then relays
  localparam int unsigned N_DI    = 5;         // digital input channels
  localparam int unsigned N_SU    = 48;        // monitored supply unit addresses
  // timing
  localparam int unsigned CLK_HZ  = 20000000;  // system clock rate
  localparam int unsigned TICK_S  = 1;         // delay tick period in seconds
  localparam int unsigned TICK_CYC = CLK_HZ * TICK_S;
  localparam int unsigned MIN_S   = 60;        // seconds per minute step
  localparam int unsigned MAX_MIN = 10;        // longest minute step
  // register map (byte addresses)
  localparam logic [7:0] OFS_CFG0   = 8'h00;   // channel config, one word each
  localparam logic [7:0] OFS_STATUS = 8'h24;   // live status, read only
  // config field positions
  localparam int unsigned F_SRC  = 0;          // [1:0] trigger source
  localparam int unsigned F_COND = 2;          // [4:2] trigger condition
  localparam int unsigned F_DI   = 5;          // [7:5] digital input channel
  localparam int unsigned F_ACT  = 8;          // [8] active level, 1 = low
  localparam int unsigned F_DLY  = 9;          // [12:9] delay code
  localparam int unsigned CFG_W  = 13;
  localparam logic [CFG_W-1:0] CFG_RST = 13'h0000;
  // status field positions
  localparam int unsigned S_OUT  = 0;          // [8:0] output asserted per channel
  localparam int unsigned S_TRG  = 9;          // [17:9] trigger met per channel
  localparam int unsigned S_DI   = 18;         // [22:18] synced digital inputs
  // trigger sources
  typedef enum logic [1:0] {
    SRC_ALARM  = 2'h0,
    SRC_SUPPLY = 2'h1,
    SRC_DI     = 2'h2
  } aort_src_t;
  // alarm kinds selected with the alarm source
  localparam logic [2:0] AL_ANY = 3'h0, AL_OV = 3'h1, AL_OL = 3'h2, AL_SHORT = 3'h3;
  localparam logic [2:0] AL_OT = 3'h4, AL_MAINS = 3'h5, AL_FAN = 3'h6;
  localparam logic [2:0] COND_ON_HIGH = 3'h0;  // supply on, or input high
  localparam logic [2:0] COND_OFF_LOW = 3'h1;  // supply off, or input low
  // delay codes: 0 immed, 1..4 = 1/5/10/30 s, 5..14 = 1..10 min
  localparam logic [3:0] DLY_MIN1 = 4'h5;
  localparam logic [3:0] DLY_MAX  = 4'he;
  typedef struct packed {
    logic [3:0] dly;
    logic       act_low;
    logic [2:0] di_sel;
    logic [2:0] cond;
    logic [1:0] src;
  } aort_cfg_t;
  // per-unit status from the supply monitor, same clock domain
  typedef struct packed {
    logic [N_SU-1:0] connected;
    logic [N_SU-1:0] running;
    logic [N_SU-1:0] remote_off;
    logic [N_SU-1:0] over_voltage_alarm;
    logic [N_SU-1:0] overload_alarm;
    logic [N_SU-1:0] short_alarm;
    logic [N_SU-1:0] over_temp_alarm;
    logic [N_SU-1:0] mains_loss_alarm;
    logic [N_SU-1:0] fan_stall_alarm;
  } aort_su_t;
  // delay code to seconds
  function automatic logic [9:0] dly_secs(input logic [3:0] code);
    logic [9:0] s;
    s = 10'h000;
    case (code)
      4'h0: s = 10'h000;
      4'h1: s = 10'h001;
      4'h2: s = 10'h005;
      4'h3: s = 10'h00a;
      4'h4: s = 10'h01e;
      default: s = 10'((((code > DLY_MAX) ? DLY_MAX : code) - DLY_MIN1 + 1) * MIN_S);
    endcase
    return s;
  endfunction
endpackage

// ---- bench/aort_top_sva.sv ----
// apb answer checks on the trigger block ports
`timescale 1ns/1ps
module aort_top_sva (
  // clock and reset
  input wire logic        clock,
  input wire logic        rst_n,
  // apb
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr
);
  import aort_pkg::*;
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);
  // access decode
  wire acc = psel && penable && !pready;
  wire bad = (paddr > OFS_STATUS) || (paddr[1:0] != 2'h0);
  wire sts = pwrite && (paddr == OFS_STATUS);
  sequence s_ans; pready ##1 !pready; endsequence
  sequence s_err; pready && pslverr; endsequence
  AST_ONE_WAIT: assert property (acc |=> s_ans)
    else $error("answer late or long");
  AST_NO_STRAY: assert property (pready |-> $past(psel && penable))
    else $error("answer without access");
  AST_ERR_WITH_READY: assert property (pslverr |-> pready)
    else $error("error outside answer");
  AST_UNMAPPED: assert property (acc && bad |=> s_err)
    else $error("unmapped access accepted");
  AST_STATUS_WR: assert property (acc && sts |=> s_err)
    else $error("status write accepted");
  AST_MAPPED: assert property (acc && !bad && !sts |=> pready && !pslverr)
    else $error("mapped access refused");
  AST_RD_HOLD: assert property (!(pready && !pwrite) |-> $stable(prdata))
    else $error("read data moved");
  AST_RD_TOP: assert property (pready && !pwrite && !pslverr |-> prdata[31:23] == 9'h000)
    else $error("unused read bits set");
endmodule
bind aort_top aort_top_sva u_sva (.clock(clock), .rst_n(rst_n), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr));

// ---- bench/aort_su_model.sv ----
// supply units: one unit shows the event picked by mode; mode 9 disconnects every unit
`timescale 1ns/1ps
module aort_su_model (
  // scenario: 0 idle, 1-6 alarms, 7 run, 8 remote off, 9 none connected
  input wire logic [3:0] mode,
  // status towards the block
  output aort_pkg::aort_su_t su_status
);
  import aort_pkg::*;
  localparam int unsigned U = 3;  // unit that shows the event
  // status vectors from mode
  always_comb begin
    su_status = '0;
    su_status.connected = (mode == 4'h9) ? '0 : '1;
    su_status.running[U] = (mode == 4'h7);
    su_status.remote_off[U] = (mode == 4'h8);
    su_status.over_voltage_alarm[U] = (mode == 4'h1);
    su_status.overload_alarm[U] = (mode == 4'h2);
    su_status.short_alarm[U] = (mode == 4'h3);
    su_status.over_temp_alarm[U] = (mode == 4'h4);
    su_status.mains_loss_alarm[U] = (mode == 4'h5);
    su_status.fan_stall_alarm[U] = (mode == 4'h6);
  end
endmodule

// ---- bench/aort_top_tb.sv ----
// self-checking bench for the trigger block
`timescale 1ns/1ps
module aort_top_tb;
  import aort_pkg::*;
  localparam int T = 20;  // cycles per delay tick, short for sim
  typedef struct packed {
    logic [3:0]  ch;
    logic [12:0] cfg;
    logic [3:0]  mode;
    logic [4:0]  di;
    logic        trg;
  } aort_row_t;
  logic        clock = 1'b0, rst_n = 1'b0;
  logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr, er_v;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd_v;
  logic [3:0]  mode = 4'h0, relay_no_closed;
  logic [4:0]  digital_input_channel = 5'h1f, do_pin;
  aort_su_t    su_status;
  aort_row_t   r;
  int          num_errors = 0, num_checks = 0;
  // channel, config, supply scenario, inputs, trigger met
  aort_row_t rows [16] = '{'{0, 13'h000, 1, 5'h1f, 1}, '{1, 13'h004, 2, 5'h1f, 0}, '{2, 13'h008, 2, 5'h1f, 1},
    '{3, 13'h00c, 3, 5'h1f, 1}, '{4, 13'h110, 4, 5'h1f, 1}, '{5, 13'h014, 5, 5'h1f, 1}, '{6, 13'h018, 6, 5'h1f, 1},
    '{7, 13'h001, 7, 5'h1f, 1}, '{8, 13'h005, 8, 5'h1f, 1}, '{0, 13'h005, 9, 5'h1f, 1}, '{1, 13'h005, 0, 5'h1f, 0},
    '{2, 13'h086, 0, 5'h0f, 1}, '{3, 13'h022, 0, 5'h1d, 0}, '{4, 13'h100, 0, 5'h1f, 0},
    '{5, 13'h100, 0, 5'h1f, 0}, '{6, 13'h006, 0, 5'h1e, 1}};
  always #25 clock = ~clock;
  aort_top #(.TICK_CYCLES(T)) dut (.clock(clock), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .su_status(su_status), .digital_input_channel(digital_input_channel), .do_pin(do_pin),
    .relay_no_closed(relay_no_closed));
  aort_su_model su (.mode(mode), .su_status(su_status));
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    num_checks++;
    if (g !== e) begin
      num_errors++;
      $display("MISMATCH %0t got %h exp %h", $time, g, e);
    end
  endtask
  // one apb transfer, waits for pready
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    do @(posedge clock); while (pready !== 1'b1);
    rd_v = prdata;
    er_v = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  function automatic logic pin(input logic [3:0] c);
    return (c < 5) ? do_pin[c] : relay_no_closed[c - 5];
  endfunction
  // delay window with one restart on the way when n is above 1
  task automatic dly(input logic [3:0] c, input logic [3:0] code, input int n);
    mode <= 4'h0;
    apb(1'b1, 8'(4 * c), {19'h0, code, 9'h000});
    repeat (4) @(posedge clock);
    mode <= 4'h1;
    if (n > 1) begin
      repeat (2 * T) @(posedge clock);
      mode <= 4'h0;
      @(posedge clock);
      mode <= 4'h1;
    end
    repeat (n * T) @(posedge clock);
    chk(pin(c), 0);
    repeat (4) @(posedge clock);
    chk(pin(c), 1);
    mode <= 4'h0;
    repeat (3) @(posedge clock);
    chk(pin(c), 0);
  endtask
  task automatic results;
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // main sequence
  initial begin
    repeat (5) @(posedge clock);
    rst_n <= 1'b1;
    apb(1'b0, 8'h10, 32'h0);
    chk(rd_v, 32'h0);
    apb(1'b0, OFS_STATUS, 32'h0);
    chk(rd_v, 32'h007c0000);
    foreach (rows[i]) begin
      r = rows[i];
      apb(1'b1, 8'(4 * r.ch), 32'(r.cfg));
      mode <= r.mode;
      digital_input_channel <= r.di;
      repeat (6) @(posedge clock);
      chk(pin(r.ch), (r.ch < 5) ? r.trg ^ r.cfg[8] : r.trg);
      apb(1'b0, OFS_STATUS, 32'h0);
      chk({rd_v[S_TRG + r.ch], rd_v[r.ch]}, {2{r.trg}});
    end
    apb(1'b1, OFS_STATUS, 32'hffffffff);
    chk(er_v, 1);
    apb(1'b0, 8'h28, 32'h0);
    chk(er_v, 1);
    apb(1'b1, 8'h22, 32'h0);
    chk(er_v, 1);
    apb(1'b1, 8'h20, 32'hffffffff);
    apb(1'b0, 8'h20, 32'h0);
    chk(rd_v, 32'h1fff);
    dly(0, 4'h1, 1);
    dly(5, 4'h2, 5);
    dly(1, 4'h3, 10);
    dly(6, 4'h4, 30);
    dly(2, 4'h5, 60);
    dly(3, 4'h6, 120);
    dly(7, 4'he, 600);
    mode <= 4'h1;
    rst_n <= 1'b0;
    repeat (2) @(posedge clock);
    chk({do_pin, relay_no_closed}, 0);
    rst_n <= 1'b1;
    repeat (5) @(posedge clock);
    chk({do_pin, relay_no_closed}, 9'h1ff);
    results();
  end
  // watchdog
  initial begin
    #(40000 * 50);
    num_errors++;
    results();
  end
endmodule
